// ==== logic/nvc_pkg.sv ====
// Types shared by the configuration programmer modules
`default_nettype none

package nvc_pkg;

	typedef enum logic [1:0] {NVC_ST_LOAD, NVC_ST_STANDBY, NVC_ST_BURN}
		nvc_state_type;

	typedef logic [15:0] nvc_word_type;

endpackage : nvc_pkg

`default_nettype wire

// ==== logic/nvc_programmer.sv ====
// Nonvolatile configuration programmer: load, burn control and status
//
// Notes on behaviour
// - Power-up copies stored settings into registers
// - One-time store has command and profile sections
// - Multi-time store offers ten single-use pages
// - After ten burns flag full, keep latest
// - Multi-time pages hold only current-sense command
// - Host access accepted once standby is reached
// - Trigger copies volatile configuration into section
// - Multi-time target uses next free page automatically
// - Both flags clear: used bits tell success
// - Array defect gives failed without blocked
// - Bad temperature or supply gives blocked only
// - Conditions lost mid-burn give both flags
// - Set used bits after successful burns
// - Blocked flag follows live conditions continuously
// - Late bad conditions refuse burn, failed stays
// - One-time burn allowed while unused and unfailed
// - Failed flag stays after blocked clears
`timescale 1ns/10ps
`default_nettype none
`include "nvc_regs.svh"

module nvc_programmer #(
	parameter int PAGES = `NVC_PAGES,
	parameter int BURN_TIME_NS = `NVC_BURN_NS
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic [`NVC_ADDR_W-1:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic temp_ok_pin, // Temperature in range
	input wire logic vin_ok_pin, // Input supply in range
	input wire logic array_defect_pin, // Storage array defect
	output logic [15:0] cmd_value, // Volatile command word
	output logic [`NVC_RANGE_W-1:0] sense_range_field, // Sense range
	output logic [`NVC_TRIM_W-1:0] sense_limit_trim_field, // Range trim
	output logic [`NVC_SCL_W-1:0] short_limit_field, // Short limit
	output logic [`NVC_START_W-1:0] startup_current_limit_field, // Start
	output logic [15:0] profile_value, // Profile data word
	output logic standby, // Host access open
	output logic busy // Load or burn in progress
);
	localparam int BURN_RAW =
		(BURN_TIME_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS;
	localparam int BURN_CYCLES = (BURN_RAW < 1) ? 1 : BURN_RAW;

	nvc_store_if #(.PAGES(PAGES)) nv ();

	nvc_store #(
		.PAGES(PAGES),
		.BURN_CYCLES(BURN_CYCLES)
	) u_store (
		.clk(clk),
		.rst(rst),
		.nv(nv.store)
	);

	nvc_pkg::nvc_state_type state_q;
	nvc_pkg::nvc_state_type state_d;
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic cond_ok;
	logic defect_sync;
	nvc_pkg::nvc_word_type cmd_q;
	nvc_pkg::nvc_word_type isns_q;
	nvc_pkg::nvc_word_type prof_q;
	logic [`NVC_SEL_W-1:0] sel_q;
	logic [`NVC_SEL_W-1:0] sel_new;
	logic burn_wr;
	logic trig;
	logic allowed;
	logic start;
	logic fail_q;
	logic disturbed_q;
	logic refused_q;
	logic full;
	logic [31:0] status;
	logic [31:0] burn_word;
	logic [31:0] rdata_q;
	logic host_wr;

	// Pins are asynchronous to clk; only the second stage is read
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
		end
		else
		begin
			pin_meta_q <= {array_defect_pin, vin_ok_pin, temp_ok_pin};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign cond_ok = pin_sync_q[0] && pin_sync_q[1];
	assign defect_sync = pin_sync_q[2];
	assign full = &nv.mtp_used;

	// Host writes open only in standby
	assign host_wr = reg_wr && (state_q == nvc_pkg::NVC_ST_STANDBY);
	assign burn_wr = host_wr && (reg_addr == `NVC_OFF_BURN);
	assign sel_new = reg_wdata[`NVC_SEL_LSB +: `NVC_SEL_W];
	assign trig = burn_wr && reg_wdata[`NVC_TRIG_BIT];

	// Which section may still take a burn
	always_comb
	begin
		case (sel_new)
			`NVC_SEC_CMD: allowed = !nv.otp_used && !fail_q;
			`NVC_SEC_PROF: allowed = !nv.prof_used && !fail_q;
			`NVC_SEC_MULTI: allowed = !full && !fail_q;
			default: allowed = 1'b0;
		endcase
	end

	// Conditions are judged at the trigger itself, not at the host check
	assign start = trig && cond_ok && allowed;

	always_comb
	begin
		case (sel_new)
			`NVC_SEC_CMD: burn_word = {isns_q, cmd_q};
			`NVC_SEC_PROF: burn_word = {16'h0000, prof_q};
			`NVC_SEC_MULTI: burn_word = {16'h0000, isns_q};
			default: burn_word = `NVC_RST_WORD;
		endcase
	end

	assign nv.start = start;
	assign nv.sel = sel_new;
	assign nv.data = burn_word;
	assign nv.defect = defect_sync;
	assign nv.abort = disturbed_q || !cond_ok;

	always_comb
	begin
		case (state_q)
			nvc_pkg::NVC_ST_LOAD:
				state_d = nvc_pkg::NVC_ST_STANDBY;
			nvc_pkg::NVC_ST_STANDBY:
				state_d = start ? nvc_pkg::NVC_ST_BURN :
					nvc_pkg::NVC_ST_STANDBY;
			nvc_pkg::NVC_ST_BURN:
				state_d = nv.done ? nvc_pkg::NVC_ST_STANDBY :
					nvc_pkg::NVC_ST_BURN;
			default:
				state_d = nvc_pkg::NVC_ST_LOAD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state_q <= nvc_pkg::NVC_ST_LOAD;
		else
			state_q <= state_d;
	end

	// Command word: loaded from one-time store, else written by host
	always_ff @(posedge clk)
	begin
		if (rst)
			cmd_q <= `NVC_RST_CMD;
		else if (state_q == nvc_pkg::NVC_ST_LOAD)
		begin
			if (nv.otp_used)
				cmd_q <= nv.otp_cmd;
		end
		else if (host_wr && reg_addr == `NVC_OFF_CMD)
			cmd_q <= reg_wdata[15:0];
	end

	// Latest multi-time page wins over the one-time copy
	always_ff @(posedge clk)
	begin
		if (rst)
			isns_q <= `NVC_RST_ISNS;
		else if (state_q == nvc_pkg::NVC_ST_LOAD)
		begin
			if (nv.mtp_used[0])
				isns_q <= nv.mtp_word;
			else if (nv.otp_used)
				isns_q <= nv.otp_isns;
		end
		else if (host_wr && reg_addr == `NVC_OFF_ISNS)
			isns_q <= reg_wdata[15:0];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			prof_q <= `NVC_RST_PROF;
		else if (state_q == nvc_pkg::NVC_ST_LOAD)
		begin
			if (nv.prof_used)
				prof_q <= nv.otp_prof;
		end
		else if (host_wr && reg_addr == `NVC_OFF_PROF)
			prof_q <= reg_wdata[15:0];
	end

	// Section choice kept for read-back; may be written before trigger
	always_ff @(posedge clk)
	begin
		if (rst)
			sel_q <= `NVC_SEC_CMD;
		else if (burn_wr)
			sel_q <= sel_new;
	end

	// Any loss of conditions during the burn is remembered to its end
	always_ff @(posedge clk)
	begin
		if (rst)
			disturbed_q <= 1'b0;
		else if (start)
			disturbed_q <= 1'b0;
		else if (state_q == nvc_pkg::NVC_ST_BURN && !cond_ok)
			disturbed_q <= 1'b1;
	end

	// Failure marks the part as scrap; only reset clears it
	always_ff @(posedge clk)
	begin
		if (rst)
			fail_q <= 1'b0;
		else if (state_q == nvc_pkg::NVC_ST_BURN && nv.done)
		begin
			if (nv.fail)
				fail_q <= 1'b1;
			else if (disturbed_q || !cond_ok)
				fail_q <= 1'b1;
		end
	end

	// Trigger that did not start a burn; next accepted one clears it
	always_ff @(posedge clk)
	begin
		if (rst)
			refused_q <= 1'b0;
		else if (trig && !start)
			refused_q <= 1'b1;
		else if (start)
			refused_q <= 1'b0;
	end

	always_comb
	begin
		status = `NVC_RST_WORD;
		status[`NVC_STS_BLOCKED] = !cond_ok;
		status[`NVC_STS_FAIL] = fail_q;
		status[`NVC_STS_OTP_USED] = nv.otp_used;
		status[`NVC_STS_PROF] = nv.prof_used;
		status[`NVC_STS_FULL] = full;
		status[`NVC_STS_BUSY] = state_q != nvc_pkg::NVC_ST_STANDBY;
		status[`NVC_STS_READY] = state_q == nvc_pkg::NVC_ST_STANDBY;
		status[`NVC_STS_REFUSED] = refused_q;
		status[`NVC_STS_USED_LSB +: PAGES] = nv.mtp_used;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_q <= `NVC_RST_WORD;
		else if (reg_rd)
		begin
			case (reg_addr)
				`NVC_OFF_CMD: rdata_q <= {16'h0000, cmd_q};
				`NVC_OFF_ISNS: rdata_q <= {16'h0000, isns_q};
				`NVC_OFF_PROF: rdata_q <= {16'h0000, prof_q};
				`NVC_OFF_BURN:
				begin
					rdata_q <= `NVC_RST_WORD;
					rdata_q[`NVC_SEL_LSB +: `NVC_SEL_W] <= sel_q;
					rdata_q[`NVC_TRIG_BIT] <=
						state_q == nvc_pkg::NVC_ST_BURN;
				end
				`NVC_OFF_STATUS: rdata_q <= status;
				default: rdata_q <= `NVC_RST_WORD;
			endcase
		end
		else
			rdata_q <= `NVC_RST_WORD;
	end

	assign reg_rdata = rdata_q;
	assign cmd_value = cmd_q;
	assign profile_value = prof_q;
	assign sense_range_field = isns_q[`NVC_RANGE_LSB +: `NVC_RANGE_W];
	assign sense_limit_trim_field = isns_q[`NVC_TRIM_LSB +: `NVC_TRIM_W];
	assign short_limit_field = isns_q[`NVC_SCL_LSB +: `NVC_SCL_W];
	assign startup_current_limit_field =
		isns_q[`NVC_START_LSB +: `NVC_START_W];
	assign standby = state_q == nvc_pkg::NVC_ST_STANDBY;
	assign busy = state_q != nvc_pkg::NVC_ST_STANDBY;

endmodule : nvc_programmer

`default_nettype wire

// ==== logic/nvc_regs.svh ====
// Register offsets, field positions, reset values and timing figures
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH

`define NVC_ADDR_W 8
`define NVC_OFF_CMD 8'h00
`define NVC_OFF_ISNS 8'h04
`define NVC_OFF_PROF 8'h08
`define NVC_OFF_BURN 8'h0c
`define NVC_OFF_STATUS 8'h10

`define NVC_RST_CMD 16'h0000
`define NVC_RST_ISNS 16'h0000
`define NVC_RST_PROF 16'h0000
`define NVC_RST_WORD 32'h0000_0000

`define NVC_SEL_LSB 0
`define NVC_SEL_W 2
`define NVC_TRIG_BIT 4
`define NVC_SEC_CMD 2'h0
`define NVC_SEC_PROF 2'h1
`define NVC_SEC_MULTI 2'h2

`define NVC_STS_BLOCKED 0
`define NVC_STS_FAIL 1
`define NVC_STS_OTP_USED 2
`define NVC_STS_PROF 3
`define NVC_STS_FULL 4
`define NVC_STS_BUSY 5
`define NVC_STS_READY 6
`define NVC_STS_REFUSED 7
`define NVC_STS_USED_LSB 8

`define NVC_RANGE_LSB 0
`define NVC_RANGE_W 2
`define NVC_TRIM_LSB 2
`define NVC_TRIM_W 8
`define NVC_SCL_LSB 10
`define NVC_SCL_W 4
`define NVC_START_LSB 14
`define NVC_START_W 2

`define NVC_PAGES 10
`define NVC_CLK_NS 10
`define NVC_BURN_NS 50000

`endif

// ==== logic/nvc_store.sv ====
// One-time sections and multi-time pages with burn timing
`timescale 1ns/10ps
`default_nettype none
`include "nvc_regs.svh"

module nvc_store #(
	parameter int PAGES = 10,
	parameter int BURN_CYCLES = 5000
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, high
	nvc_store_if.store nv // Store side of the link to the control
);
	localparam int CW = $clog2(BURN_CYCLES + 1);
	localparam int PW = $clog2(PAGES + 1);

	logic act_q;
	logic [CW-1:0] cnt_q;
	logic [1:0] sel_q;
	logic [31:0] buf_q;
	logic bad_q;
	logic finish;
	logic ok;
	logic [PW-1:0] fill_q;
	nvc_pkg::nvc_word_type page_q [PAGES];
	nvc_pkg::nvc_word_type otp_cmd_q;
	nvc_pkg::nvc_word_type otp_isns_q;
	nvc_pkg::nvc_word_type otp_prof_q;
	logic otp_used_q;
	logic prof_used_q;

	assign finish = act_q && (cnt_q == CW'(1));
	assign nv.done = finish;
	assign nv.fail = bad_q || nv.defect;
	assign ok = finish && !nv.fail && !nv.abort;

	// Data is latched at start so the burn is immune to later writes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			act_q <= 1'b0;
			cnt_q <= '0;
			sel_q <= `NVC_SEC_CMD;
			buf_q <= `NVC_RST_WORD;
			bad_q <= 1'b0;
		end
		else if (nv.start && !act_q)
		begin
			act_q <= 1'b1;
			cnt_q <= CW'(BURN_CYCLES);
			sel_q <= nv.sel;
			buf_q <= nv.data;
			bad_q <= nv.defect;
		end
		else if (act_q)
		begin
			cnt_q <= cnt_q - CW'(1);
			bad_q <= bad_q || nv.defect;
			if (finish)
				act_q <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			otp_cmd_q <= `NVC_RST_CMD;
			otp_isns_q <= `NVC_RST_ISNS;
			otp_used_q <= 1'b0;
		end
		else if (ok && sel_q == `NVC_SEC_CMD)
		begin
			otp_cmd_q <= buf_q[15:0];
			otp_isns_q <= buf_q[31:16];
			otp_used_q <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			otp_prof_q <= `NVC_RST_PROF;
			prof_used_q <= 1'b0;
		end
		else if (ok && sel_q == `NVC_SEC_PROF)
		begin
			otp_prof_q <= buf_q[15:0];
			prof_used_q <= 1'b1;
		end
	end

	// Pages fill in order, so the count is also the next free page
	always_ff @(posedge clk)
	begin
		if (rst)
			fill_q <= '0;
		else if (ok && sel_q == `NVC_SEC_MULTI && fill_q < PW'(PAGES))
			fill_q <= fill_q + PW'(1);
	end

	for (genvar i = 0; i < PAGES; i++)
	begin : g_page
		always_ff @(posedge clk)
		begin
			if (rst)
				page_q[i] <= `NVC_RST_ISNS;
			else if (ok && sel_q == `NVC_SEC_MULTI && fill_q == PW'(i))
				page_q[i] <= buf_q[15:0];
		end
		assign nv.mtp_used[i] = fill_q > PW'(i);
	end

	assign nv.mtp_word = (fill_q == '0) ? `NVC_RST_ISNS :
		page_q[fill_q - PW'(1)];
	assign nv.otp_cmd = otp_cmd_q;
	assign nv.otp_isns = otp_isns_q;
	assign nv.otp_prof = otp_prof_q;
	assign nv.otp_used = otp_used_q;
	assign nv.prof_used = prof_used_q;

endmodule : nvc_store

`default_nettype wire

// ==== logic/nvc_store_if.sv ====
// Link between the programmer control and its nonvolatile store
`timescale 1ns/10ps
`default_nettype none

interface nvc_store_if #(parameter int PAGES = 10) ();
	logic start;
	logic [1:0] sel;
	logic [31:0] data;
	logic abort;
	logic defect;
	logic done;
	logic fail;
	nvc_pkg::nvc_word_type otp_cmd;
	nvc_pkg::nvc_word_type otp_isns;
	nvc_pkg::nvc_word_type otp_prof;
	logic otp_used;
	logic prof_used;
	nvc_pkg::nvc_word_type mtp_word;
	logic [PAGES-1:0] mtp_used;

	modport ctrl (output start, sel, data, abort, defect, input done, fail,
		otp_cmd, otp_isns, otp_prof, otp_used, prof_used, mtp_word, mtp_used);
	modport store (input start, sel, data, abort, defect, output done, fail,
		otp_cmd, otp_isns, otp_prof, otp_used, prof_used, mtp_word, mtp_used);
endinterface : nvc_store_if

`default_nettype wire

// ==== test/nvc_host_model.sv ====
// Host controller model driving the register port
`timescale 1ns/10ps
`default_nettype none

module nvc_host_model (
	input wire logic clk, // Clock
	output var logic [7:0] reg_addr, // Address
	output var logic [31:0] reg_wdata, // Write data
	output var logic reg_wr, // Write strobe
	output var logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata // Read data
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Lines are inverted when idle so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd
endmodule : nvc_host_model

`default_nettype wire

// ==== test/nvc_prog_monitor.sv ====
// Port-level assertions for the configuration programmer
`timescale 1ns/10ps
`default_nettype none

module nvc_prog_monitor #(
	parameter int PAGES = 10,
	parameter int BURN_TIME_NS = 50000
) (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic [7:0] reg_addr, // Address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [31:0] reg_rdata, // Read data
	input wire logic temp_ok_pin, // Temperature ok
	input wire logic vin_ok_pin, // Supply ok
	input wire logic [15:0] cmd_value, // Command word
	input wire logic [1:0] sense_range_field, // Range
	input wire logic [7:0] sense_limit_trim_field, // Trim
	input wire logic [3:0] short_limit_field, // Short limit
	input wire logic [1:0] startup_current_limit_field, // Start limit
	input wire logic standby, // Standby
	input wire logic busy // Busy
);
	localparam int BURN = (BURN_TIME_NS + 9) / 10;
	logic [15:0] busy_cnt_q;
	logic [15:0] wlo;
	assign wlo = reg_wdata[15:0];

	// Load and burn both count, load is far shorter
	always_ff @(posedge clk)
		if (rst || !busy)
			busy_cnt_q <= 16'h0000;
		else
			busy_cnt_q <= busy_cnt_q + 16'h0001;

	default clocking dc @(posedge clk); endclocking
	default disable iff rst;

	// A load also ends a busy stretch, but only after one cycle
	sequence end_s;
		busy ##1 !busy;
	endsequence
	sequence sts_rd_s;
		reg_rd && reg_addr == 8'h10;
	endsequence
	sequence bad_s;
		(!temp_ok_pin || !vin_ok_pin)[*4];
	endsequence
	sequence good_s;
		(temp_ok_pin && vin_ok_pin)[*4];
	endsequence

	rdata_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("rdata not idle");
	load_end_a: assert property (
		$fell(rst) |-> busy ##1 standby) else $error("load too long");
	burn_end_a: assert property (
		end_s ##0 busy_cnt_q != 16'h0001 |-> busy_cnt_q == 16'(BURN))
		else $error("burn length wrong");
	busy_cap_a: assert property (
		busy |-> busy_cnt_q < BURN) else $error("busy too long");
	cmd_write_a: assert property (
		standby && reg_wr && reg_addr == 8'h00 |=> cmd_value == $past(wlo))
		else $error("command write lost");
	sense_write_a: assert property (
		standby && reg_wr && reg_addr == 8'h04 |=> {startup_current_limit_field,
		short_limit_field, sense_limit_trim_field, sense_range_field} == $past(wlo))
		else $error("sense fields wrong");
	busy_hold_a: assert property (
		busy && reg_wr |=> $stable(cmd_value)) else $error("write during burn");
	blocked_a: assert property (
		bad_s ##0 sts_rd_s |=> reg_rdata[0]) else $error("blocked not shown");
	unblocked_a: assert property (
		good_s ##0 sts_rd_s |=> !reg_rdata[0]) else $error("blocked stuck");
endmodule : nvc_prog_monitor

bind nvc_programmer nvc_prog_monitor #(.PAGES(PAGES),
	.BURN_TIME_NS(BURN_TIME_NS)) i_mon (.clk(clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_ok_pin(temp_ok_pin),
	.vin_ok_pin(vin_ok_pin), .cmd_value(cmd_value),
	.sense_range_field(sense_range_field),
	.sense_limit_trim_field(sense_limit_trim_field),
	.short_limit_field(short_limit_field),
	.startup_current_limit_field(startup_current_limit_field),
	.standby(standby), .busy(busy));

`default_nettype wire

// ==== test/test_nonvolatile_config_programmer.sv ====
// Self-checking bench for the configuration programmer
`timescale 1ns/10ps
`default_nettype none
`include "nvc_regs.svh"

module test_nonvolatile_config_programmer;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic temp_ok = 1'b1;
	logic vin_ok = 1'b1;
	logic defect = 1'b0;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [15:0] cmd;
	logic [1:0] rng;
	logic [7:0] trim;
	logic [3:0] scl;
	logic [1:0] stl;
	logic [15:0] prof;
	logic standby;
	logic busy;
	int err_total = 0;
	int total_checks = 0;

	initial
	begin
		forever #5 clk = ~clk;
	end

	nvc_host_model i_host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));

	nvc_programmer #(.PAGES(10), .BURN_TIME_NS(50)) i_dut (.clk(clk),
		.rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .temp_ok_pin(temp_ok),
		.vin_ok_pin(vin_ok), .array_defect_pin(defect), .cmd_value(cmd),
		.sense_range_field(rng), .sense_limit_trim_field(trim),
		.short_limit_field(scl), .startup_current_limit_field(stl),
		.profile_value(prof), .standby(standby), .busy(busy));

	task automatic conclude;
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task automatic wait_standby;
		for (int i = 0; i < 60; i++)
		begin
			@(posedge clk);
			#1;
			if (standby === 1'b1)
				return;
		end
		err_total++;
		conclude();
	endtask : wait_standby

	// Status fields compared under a mask
	task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
		i_host.rd(`NVC_OFF_STATUS, d);
		chk(d & mask, exp);
	endtask : stat

	// Pins pass a two-stage sync, so settle before acting
	task automatic pins(input logic t, input logic v, input logic f);
		@(posedge clk);
		temp_ok <= t;
		vin_ok <= v;
		defect <= f;
		repeat (4) @(posedge clk);
	endtask : pins

	task automatic reset_dut;
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wait_standby();
		repeat (2) @(posedge clk);
	endtask : reset_dut

	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wait_standby();
		repeat (2) @(posedge clk);
		stat(32'h0003_ffff, 32'h0000_0040);
		chk(cmd, 32'h0000_0000);
		i_host.wr(`NVC_OFF_CMD, 32'h0000_1234);
		i_host.wr(`NVC_OFF_ISNS, 32'h0000_a5c3);
		#1 chk({stl, scl, trim, rng}, 32'h0000_a5c3);
		i_host.rd(`NVC_OFF_CMD, d);
		chk(d, 32'h0000_1234);
		i_host.rd(8'h20, d);
		chk(d, 32'h0000_0000);
		pins(1'b0, 1'b1, 1'b0);
		stat(32'h0000_0001, 32'h0000_0001);
		pins(1'b1, 1'b0, 1'b0);
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0010);
		stat(32'h0000_00a7, 32'h0000_0081);
		pins(1'b1, 1'b1, 1'b0);
		stat(32'h0000_0003, 32'h0000_0000);
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0010);
		i_host.wr(`NVC_OFF_CMD, 32'h0000_ffff);
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0011);
		wait_standby();
		chk(cmd, 32'h0000_1234);
		i_host.rd(`NVC_OFF_BURN, d);
		chk(d, 32'h0000_0000);
		stat(32'h0000_00ff, 32'h0000_0044);
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0010);
		stat(32'h0000_0084, 32'h0000_0084);
		i_host.wr(`NVC_OFF_PROF, 32'h0000_5a5a);
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0011);
		wait_standby();
		stat(32'h0000_008c, 32'h0000_000c);
		chk(prof, 32'h0000_5a5a);
		for (int i = 0; i < 10; i++)
		begin
			i_host.wr(`NVC_OFF_ISNS, 32'h0000_0101 * (i + 1));
			i_host.wr(`NVC_OFF_BURN, 32'h0000_0012);
			wait_standby();
			stat(32'h0003_ff00, ((32'h1 << (i + 1)) - 1) << 8);
		end
		stat(32'h0000_0010, 32'h0000_0010);
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0012);
		stat(32'h0003_ff90, 32'h0003_ff90);
		reset_dut();
		// Unused section code must be refused without burning
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0013);
		stat(32'h0000_00af, 32'h0000_0080);
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0010);
		temp_ok <= 1'b0;
		wait_standby();
		stat(32'h0000_0007, 32'h0000_0003);
		pins(1'b1, 1'b1, 1'b0);
		stat(32'h0000_0007, 32'h0000_0002);
		reset_dut();
		i_host.wr(`NVC_OFF_BURN, 32'h0000_0011);
		defect <= 1'b1;
		wait_standby();
		stat(32'h0000_000b, 32'h0000_0002);
		conclude();
	end
endmodule : test_nonvolatile_config_programmer

`default_nettype wire
